// file: design/bmid_decoder.sv
// Boot mode index decoder: samples the stored configuration word after each reset,
// checks the index, and presents start mode, debug pin and clock choice to the core.
// Assumes user_config_word_i is stable from reset release until the core is released.
`timescale 1ns/100ps
`include "bmid_params.svh"
module bmid_decoder #(
	parameter bit LARGE_FLASH = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Stored configuration word
	input wire logic [31:0] user_config_word_i,
	// Core start-up controls
	output logic core_reset_n_o,
	output bmid_pkg::bmid_mode_type boot_mode_o,
	output logic [15:0] start_addr_o,
	output logic [7:0] boot_config_byte0_o,
	// Single-pin debug
	output logic single_pin_debug_en_o,
	output logic [1:0] single_pin_debug_sel_o,
	// Clock setup and peripheral enable
	output logic active_clock_select_o,
	output logic flash_wait_state_o,
	output logic peripherals_en_o
);
	localparam logic [3:0] SETTLE = 4'(`BMID_SETTLE_CYC);

	logic [1:0] rst_sync_ff;
	logic rst_n;
	bmid_pkg::bmid_state_s_type st_ff;
	bmid_pkg::bmid_state_s_type nxt_st;
	logic [7:0] idx;
	logic [7:0] cmp;
	logic valid;

	// Reset is released through two stages; the core soft reset also lands here [R9]
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	assign idx = user_config_word_i[`BMID_IDX_LSB +: 8]; // [R10]
	assign cmp = user_config_word_i[`BMID_CMP_LSB +: 8]; // [R13]
	assign valid = 8'(idx + cmp + 8'h01) == 8'h00; // [R1]

	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			bmid_pkg::ST_SETTLE: begin
				// Storage read-out settles before the word is trusted
				if (st_ff.cnt == SETTLE) begin
					nxt_st.state = bmid_pkg::ST_DECODE;
				end else begin
					nxt_st.cnt = 4'(st_ff.cnt + 4'h1);
				end
			end
			bmid_pkg::ST_DECODE: begin
				// Anything unrecognised falls back to the loader so the part stays recoverable
				nxt_st.mode = bmid_pkg::BOOT_LOADER; // [R2]
				nxt_st.pin = 2'h0;
				nxt_st.dbg_en = 1'b0;
				nxt_st.start_addr = `BMID_ADDR_USER;
				nxt_st.index = idx;
				if (idx == `BMID_IDX_LOADER &&
						(cmp == `BMID_CMP_BLANK_A || cmp == `BMID_CMP_BLANK_B)) begin
					nxt_st.mode = bmid_pkg::BOOT_LOADER; // [R3]
				end else if (valid) begin
					case (idx)
						`BMID_IDX_USER: begin
							nxt_st.mode = bmid_pkg::BOOT_USER; // [R4] [R14]
						end
						`BMID_IDX_ALT_LOADER: begin
							if (LARGE_FLASH) begin
								nxt_st.mode = bmid_pkg::BOOT_ALT_LOADER; // [R4]
								nxt_st.start_addr = `BMID_ADDR_ALT_LOADER; // [R5]
							end
						end
						`BMID_IDX_DIAG0, `BMID_IDX_DIAG1, `BMID_IDX_DIAG2: begin
							nxt_st.mode = bmid_pkg::BOOT_DIAG; // [R6] [R14]
							nxt_st.pin = idx[2:1];
							nxt_st.dbg_en = 1'b1; // [R8]
						end
						`BMID_IDX_DEBUG0, `BMID_IDX_DEBUG1, `BMID_IDX_DEBUG2: begin
							nxt_st.mode = bmid_pkg::BOOT_DEBUG; // [R7]
							nxt_st.pin = idx[2:1];
							nxt_st.dbg_en = 1'b1; // [R8]
						end
						default: begin
							nxt_st.mode = bmid_pkg::BOOT_LOADER;
						end
					endcase
				end
				nxt_st.clk_fast = user_config_word_i[`BMID_CLKSEL_BIT]; // [R11] [R15]
				nxt_st.wait_state = user_config_word_i[`BMID_CLKSEL_BIT]; // [R15]
				nxt_st.periph_en = user_config_word_i[`BMID_PERIPH_BIT];
				nxt_st.state = bmid_pkg::ST_RUN;
			end
			bmid_pkg::ST_RUN: begin
				// Core leaves reset only after clock and mode are applied [R11] [R16]
				nxt_st.core_run = 1'b1;
			end
			default: begin
				nxt_st.state = bmid_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{state: bmid_pkg::ST_SETTLE, cnt: 4'h0, mode: bmid_pkg::BOOT_LOADER,
				pin: 2'h0, dbg_en: 1'b0, clk_fast: 1'b0, wait_state: 1'b0,
				periph_en: 1'b0, start_addr: 16'h0000, index: 8'h00, core_run: 1'b0};
		end else begin
			st_ff <= nxt_st; // [R16]
		end
	end

	assign core_reset_n_o = st_ff.core_run;
	assign boot_mode_o = st_ff.mode;
	assign start_addr_o = st_ff.start_addr;
	assign boot_config_byte0_o = st_ff.index;
	assign single_pin_debug_en_o = st_ff.dbg_en;
	assign single_pin_debug_sel_o = st_ff.pin;
	assign active_clock_select_o = st_ff.clk_fast;
	assign flash_wait_state_o = st_ff.wait_state;
	assign peripherals_en_o = st_ff.periph_en;

	a_core_held: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state != bmid_pkg::ST_RUN |-> !core_reset_n_o)
		else $error("core released before decode");
	a_mode_stable: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		core_reset_n_o |=> $stable(boot_mode_o) && $stable(start_addr_o) && core_reset_n_o)
		else $error("mode changed while core runs");
	a_dbg_mode: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
		single_pin_debug_en_o == (boot_mode_o == bmid_pkg::BOOT_DIAG ||
			boot_mode_o == bmid_pkg::BOOT_DEBUG))
		else $error("debug enable disagrees with mode");
	a_user_valid: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
		st_ff.state == bmid_pkg::ST_DECODE && idx == `BMID_IDX_USER && valid
		|=> boot_mode_o == bmid_pkg::BOOT_USER && start_addr_o == 16'h0000)
		else $error("productive user mode not decoded");
	a_invalid_loader: assert property (@(posedge clk_i) disable iff (!rst_n) // [R1]
		st_ff.state == bmid_pkg::ST_DECODE && !valid |=> boot_mode_o == bmid_pkg::BOOT_LOADER)
		else $error("invalid index not sent to loader");
	a_alt_addr: assert property (@(posedge clk_i) disable iff (!rst_n) // [R5]
		boot_mode_o == bmid_pkg::BOOT_ALT_LOADER |-> start_addr_o == 16'hff40)
		else $error("alternate loader start address wrong");
	a_debug_pin: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h64 && cmp == 8'h9b
		|=> boot_mode_o == bmid_pkg::BOOT_DEBUG && single_pin_debug_sel_o == 2'h2)
		else $error("debug pin two not selected");
	a_clock_sel: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
		$rose(core_reset_n_o) |-> active_clock_select_o == flash_wait_state_o
		&& active_clock_select_o == $past(user_config_word_i[31], 2))
		else $error("clock mode not applied before start");
	a_decode_time: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		$rose(rst_n) |-> ##[1:8] core_reset_n_o)
		else $error("core not released in time");

	// Start-up sequence: settle and decode are left exactly as the walk describes; run is held until reset

	a_reset_view: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		$rose(rst_n) |-> !core_reset_n_o && boot_mode_o == bmid_pkg::BOOT_LOADER
		&& !single_pin_debug_en_o)
		else $error("outputs not cleared by reset");

	a_settle_bound: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_SETTLE |-> st_ff.cnt <= SETTLE)
		else $error("settle counter overran");

	a_settle_exit: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_SETTLE && st_ff.cnt == SETTLE
		|=> st_ff.state == bmid_pkg::ST_DECODE)
		else $error("settle did not end in decode");

	a_decode_once: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_DECODE |=> st_ff.state == bmid_pkg::ST_RUN)
		else $error("decode lasted more than one cycle");

	a_run_stays: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_RUN |=> st_ff.state == bmid_pkg::ST_RUN)
		else $error("run state left without reset");

	a_core_follows: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_RUN |=> core_reset_n_o)
		else $error("core not released after decode");

	// Loader selection, including the blank-word exception to the check

	a_loader_blank: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h00 && cmp == 8'hff
		|=> boot_mode_o == bmid_pkg::BOOT_LOADER && !single_pin_debug_en_o)
		else $error("index 00 with ff not sent to loader");

	a_loader_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h00 && cmp == 8'h00
		|=> boot_mode_o == bmid_pkg::BOOT_LOADER && !single_pin_debug_en_o)
		else $error("index 00 with 00 not sent to loader");

	a_reserved_idx: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
		st_ff.state == bmid_pkg::ST_DECODE && valid && !(idx inside {8'h00, 8'h01, 8'h10,
			8'h50, 8'h52, 8'h54, 8'h60, 8'h62, 8'h64})
		|=> boot_mode_o == bmid_pkg::BOOT_LOADER)
		else $error("reserved index not sent to loader");

	a_alt_decode: assert property (@(posedge clk_i) disable iff (!rst_n) // [R4]
		st_ff.state == bmid_pkg::ST_DECODE && LARGE_FLASH && idx == 8'h01 && cmp == 8'hfe
		|=> boot_mode_o == bmid_pkg::BOOT_ALT_LOADER && start_addr_o == 16'hff40)
		else $error("alternate loader not decoded");

	// Diagnostic and debug pin choice

	a_diag_pin0: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h50 && cmp == 8'haf
		|=> boot_mode_o == bmid_pkg::BOOT_DIAG && single_pin_debug_sel_o == 2'h0)
		else $error("diagnostic pin zero not selected");

	a_diag_pin1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h52 && cmp == 8'had
		|=> boot_mode_o == bmid_pkg::BOOT_DIAG && single_pin_debug_sel_o == 2'h1)
		else $error("diagnostic pin one not selected");

	a_diag_pin2: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h54 && cmp == 8'hab
		|=> boot_mode_o == bmid_pkg::BOOT_DIAG && single_pin_debug_sel_o == 2'h2)
		else $error("diagnostic pin two not selected");

	a_debug_pin0: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h60 && cmp == 8'h9f
		|=> boot_mode_o == bmid_pkg::BOOT_DEBUG && single_pin_debug_sel_o == 2'h0)
		else $error("debug pin zero not selected");

	a_debug_pin1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
		st_ff.state == bmid_pkg::ST_DECODE && idx == 8'h62 && cmp == 8'h9d
		|=> boot_mode_o == bmid_pkg::BOOT_DEBUG && single_pin_debug_sel_o == 2'h1)
		else $error("debug pin one not selected");

	a_sel_range: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
		single_pin_debug_sel_o != 2'h3)
		else $error("debug pin choice out of range");

	a_dbg_off: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
		!single_pin_debug_en_o |-> single_pin_debug_sel_o == 2'h0)
		else $error("pin chosen while debug interface off");

	a_dbg_fixed: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
		core_reset_n_o |=> $stable(single_pin_debug_en_o) && $stable(single_pin_debug_sel_o))
		else $error("debug interface changed while core runs");

	// Start address, index byte, clock choice and peripheral enable

	a_user_addr: assert property (@(posedge clk_i) disable iff (!rst_n) // [R14]
		boot_mode_o inside {bmid_pkg::BOOT_USER, bmid_pkg::BOOT_DIAG, bmid_pkg::BOOT_DEBUG}
		|-> start_addr_o == 16'h0000)
		else $error("user start address not zero");

	a_index_byte: assert property (@(posedge clk_i) disable iff (!rst_n) // [R10]
		st_ff.state == bmid_pkg::ST_DECODE |=> boot_config_byte0_o == $past(idx))
		else $error("index byte not captured");

	a_index_fixed: assert property (@(posedge clk_i) disable iff (!rst_n) // [R9]
		core_reset_n_o |=> $stable(boot_config_byte0_o))
		else $error("index byte changed without reset");

	a_clk_decode: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
		st_ff.state == bmid_pkg::ST_DECODE
		|=> active_clock_select_o == $past(user_config_word_i[31]))
		else $error("clock choice not taken from bit 31");

	a_wait_pair: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
		active_clock_select_o == flash_wait_state_o)
		else $error("wait state disagrees with clock mode");

	a_clock_fixed: assert property (@(posedge clk_i) disable iff (!rst_n) // [R11]
		core_reset_n_o |=> $stable(active_clock_select_o) && $stable(flash_wait_state_o))
		else $error("clock mode changed while core runs");

	a_periph_bit: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		st_ff.state == bmid_pkg::ST_DECODE
		|=> peripherals_en_o == $past(user_config_word_i[30]))
		else $error("peripheral enable not taken from bit 30");

	a_periph_fixed: assert property (@(posedge clk_i) disable iff (!rst_n) // [R16]
		core_reset_n_o |=> $stable(peripherals_en_o))
		else $error("peripheral enable changed while core runs");
endmodule

// file: design/bmid_params.svh
// Constants for the boot mode index decoder: field positions, codes and timing.
// Assumes the configuration word is presented by non-volatile storage after reset.
// Overview of operation
// R1: Index valid when index plus complement plus one zero
// R2: Blank or unprogrammed word defaults to serial loader
// R3: Index 00, complement FF or 00 selects loader
// R4: 10/EF productive user, 01/FE alternate loader; others reserved
// R5: Alternate loader starts at FF40, large variant only
// R6: Indices 50, 52, 54 select diagnostic user mode
// R7: Indices 60, 62, 64 select on-chip debug mode
// R8: Single-pin debug enabled only in debug or diagnostic
// R9: Rewritten index takes effect after the soft reset
// R10: Index sits in word bits 7 to 0
// R11: Active clock mode chosen before user code runs
// R12: Software disables watchdog before rewriting the index; core model sets wdt_off_ff in the same cycle as the rewrite
// R13: Complement sits in word bits 15 to 8
// R14: User and diagnostic modes start at address zero
// R15: Bit 31 picks 8 or 24 MHz with waits
// R16: Sample once per reset, hold core until decoded
`ifndef BMID_PARAMS_SVH
`define BMID_PARAMS_SVH
`define BMID_IDX_LSB 0
`define BMID_CMP_LSB 8
`define BMID_PERIPH_BIT 30
`define BMID_CLKSEL_BIT 31
`define BMID_IDX_LOADER 8'h00
`define BMID_CMP_BLANK_A 8'hff
`define BMID_CMP_BLANK_B 8'h00
`define BMID_IDX_ALT_LOADER 8'h01
`define BMID_IDX_USER 8'h10
`define BMID_IDX_DIAG0 8'h50
`define BMID_IDX_DIAG1 8'h52
`define BMID_IDX_DIAG2 8'h54
`define BMID_IDX_DEBUG0 8'h60
`define BMID_IDX_DEBUG1 8'h62
`define BMID_IDX_DEBUG2 8'h64
`define BMID_ADDR_USER 16'h0000
`define BMID_ADDR_ALT_LOADER 16'hff40
`define BMID_SETTLE_NS 8
`define BMID_CLK_PERIOD_NS 4
`define BMID_SETTLE_CYC ((`BMID_SETTLE_NS + `BMID_CLK_PERIOD_NS - 1) / `BMID_CLK_PERIOD_NS)
`endif

// file: design/bmid_pkg.sv
// Types shared by the boot mode index decoder.
// Assumes nothing of its surroundings.
package bmid_pkg;
	typedef enum logic [2:0] {
		BOOT_LOADER = 3'h0,
		BOOT_ALT_LOADER = 3'h1,
		BOOT_USER = 3'h2,
		BOOT_DIAG = 3'h3,
		BOOT_DEBUG = 3'h4
	} bmid_mode_type;
	typedef enum logic [1:0] {
		ST_SETTLE = 2'h0,
		ST_DECODE = 2'h1,
		ST_RUN = 2'h2
	} bmid_state_type;
	typedef struct packed {
		bmid_state_type state;
		logic [3:0] cnt;
		bmid_mode_type mode;
		logic [1:0] pin;
		logic dbg_en;
		logic clk_fast;
		logic wait_state;
		logic periph_en;
		logic [15:0] start_addr;
		logic [7:0] index;
		logic core_run;
	} bmid_state_s_type;
endpackage

// file: test/bmid_core_model.sv
// Far-side model: boot code holding the stored word and rewriting it on request.
// Assumes rewrite requests come only while the core runs.
`timescale 1ns/100ps
module bmid_core_model (
	// Clock and core state
	input wire logic clk_i,
	input wire logic core_reset_n_i,
	// Rewrite request
	input wire logic wr_i,
	input wire logic [31:0] wr_word_i,
	// Towards the decoder
	output logic soft_rst_n_o,
	output logic [31:0] word_o
);
	logic wdt_off_ff = 1'b0;
	initial word_o = 32'h0000_0000;
	initial soft_rst_n_o = 1'b1;
	always @(posedge clk_i) begin
		if (wr_i && core_reset_n_i) begin
			wdt_off_ff <= 1'b1; // Watchdog off so it cannot cut the rewrite
			word_o <= wr_word_i;
			soft_rst_n_o <= 1'b0; // One-cycle soft reset after the rewrite
		end else begin
			soft_rst_n_o <= 1'b1;
		end
	end
endmodule

// file: test/boot_mode_index_decoder_tb.sv
// Testbench: boots the decoder with a table of stored words and checks the outcome.
// Assumes the core model issues the soft reset after every rewrite.
`timescale 1ns/100ps
`include "bmid_params.svh"
module boot_mode_index_decoder_tb;
	logic clk = 1'b0;
	logic por_n = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wr_word = 32'h0000_0000;
	logic soft_n;
	logic core_n;
	logic [31:0] word;
	bmid_pkg::bmid_mode_type mode;
	logic [15:0] addr;
	logic [7:0] byte0;
	logic [1:0] sel;
	logic dbg_en;
	logic fast;
	logic wst;
	logic per;
	int err_count = 0;
	int num_checks = 0;
	logic [31:0] words [13] = '{32'h0000_ff00, 32'h0000_0000, 32'h8000_fe01, 32'h4000_ef10,
		32'h0000_af50, 32'h8000_ad52, 32'h0000_ab54, 32'h0000_9f60, 32'h0000_9d62,
		32'hc000_9b64, 32'h0000_ee10, 32'h0000_df20, 32'h0000_0100};
	always #2 clk = ~clk;
	bmid_core_model core (.clk_i(clk), .core_reset_n_i(core_n), .wr_i(wr),
		.wr_word_i(wr_word), .soft_rst_n_o(soft_n), .word_o(word));
	bmid_decoder dut (.clk_i(clk), .rst_n_i(por_n & soft_n), .user_config_word_i(word),
		.core_reset_n_o(core_n), .boot_mode_o(mode), .start_addr_o(addr),
		.boot_config_byte0_o(byte0), .single_pin_debug_en_o(dbg_en),
		.single_pin_debug_sel_o(sel), .active_clock_select_o(fast),
		.flash_wait_state_o(wst), .peripherals_en_o(per));
	task automatic complete_run();
		$display("Checks made %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Counts edges from reset release until the core is let go
	task automatic wait_core();
		int n;
		n = 0;
		chk("core held", 16'h0, {15'h0, core_n});
		while (core_n !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("release bound", 16'h1, {15'h0, n <= 8});
		if (n >= 20) begin
			err_count++;
			complete_run();
		end
	endtask
	task automatic boot(input logic [31:0] w);
		@(posedge clk);
		wr <= 1'b1;
		wr_word <= w;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
		wait_core();
	endtask
	task automatic check(input logic [31:0] w);
		logic [7:0] idx;
		bmid_pkg::bmid_mode_type em;
		logic en;
		idx = w[7:0];
		em = bmid_pkg::BOOT_LOADER;
		if (idx + w[15:8] + 8'h01 == 8'h00) begin
			if (idx == `BMID_IDX_ALT_LOADER)
				em = bmid_pkg::BOOT_ALT_LOADER;
			if (idx == `BMID_IDX_USER)
				em = bmid_pkg::BOOT_USER;
			if (idx inside {8'h50, 8'h52, 8'h54})
				em = bmid_pkg::BOOT_DIAG;
			if (idx inside {8'h60, 8'h62, 8'h64})
				em = bmid_pkg::BOOT_DEBUG;
		end
		en = em inside {bmid_pkg::BOOT_DIAG, bmid_pkg::BOOT_DEBUG};
		chk("mode", {13'h0, em}, {13'h0, mode});
		chk("start", em == bmid_pkg::BOOT_ALT_LOADER ? 16'hff40 : 16'h0000, addr);
		chk("byte0", {8'h0, idx}, {8'h0, byte0});
		chk("dbg en", {15'h0, en}, {15'h0, dbg_en});
		chk("dbg sel", en ? {14'h0, idx[2:1]} : 16'h0, {14'h0, sel});
		chk("clock", {14'h0, w[31], w[31]}, {14'h0, fast, wst});
		chk("periph", {15'h0, w[30]}, {15'h0, per});
	endtask
	initial begin
		repeat (2) @(posedge clk);
		por_n <= 1'b1;
		@(posedge clk);
		#1;
		wait_core();
		check(32'h0000_0000);
		foreach (words[i]) begin
			boot(words[i]);
			check(words[i]);
		end
		complete_run();
	end
endmodule
